// ===== design/pmw_defines.svh
// Offsets, field positions, reset values and timing counts of the PHY management block.
`ifndef PMW_DEFINES_SVH
`define PMW_DEFINES_SVH
`define PMW_CLK_NS 10
`define PMW_SRST_NS 100
`define PMW_SRST_CYC ((`PMW_SRST_NS + `PMW_CLK_NS - 1) / `PMW_CLK_NS)
`define PMW_PW0_NS 80
`define PMW_PW1_NS 160
`define PMW_PW2_NS 320
`define PMW_PW3_NS 640
`define PMW_PW0_CYC ((`PMW_PW0_NS + `PMW_CLK_NS - 1) / `PMW_CLK_NS)
`define PMW_PW1_CYC ((`PMW_PW1_NS + `PMW_CLK_NS - 1) / `PMW_CLK_NS)
`define PMW_PW2_CYC ((`PMW_PW2_NS + `PMW_CLK_NS - 1) / `PMW_CLK_NS)
`define PMW_PW3_CYC ((`PMW_PW3_NS + `PMW_CLK_NS - 1) / `PMW_CLK_NS)
`define PMW_REG_CTRL 5'h00
`define PMW_REG_STAT 5'h01
`define PMW_REG_ID_HI 5'h02
`define PMW_REG_ID_LO 5'h03
`define PMW_REG_ADV 5'h04
`define PMW_REG_INT_EN 5'h12
`define PMW_REG_INT_ST 5'h13
`define PMW_REG_EXT_ADDR 5'h1E
`define PMW_REG_EXT_DATA 5'h1F
`define PMW_EXT_WAKE_CTRL 16'h4000
`define PMW_EXT_WAKE_CFG 16'h4003
`define PMW_EXT_MAC_HI 16'h4004
`define PMW_EXT_MAC_MID 16'h4005
`define PMW_EXT_MAC_LO 16'h4006
`define PMW_CTRL_RST 16'h1140
`define PMW_CTRL_RW_MASK 16'h7DC0
`define PMW_CTRL_SWC_MASK 16'h4C80
`define PMW_B_LOOP 14
`define PMW_B_SPD_L 13
`define PMW_B_AN_EN 12
`define PMW_B_PDN 11
`define PMW_B_ISO 10
`define PMW_B_RESTART 9
`define PMW_B_DUP 8
`define PMW_B_COLT 7
`define PMW_B_SPD_M 6
`define PMW_STAT_FIXED 16'h7949
`define PMW_ADV_RST 16'h1DE1
`define PMW_ADV_RW_MASK 16'hBDE0
`define PMW_ADV_FIXED 16'h0001
`define PMW_B_WAKE_EN 2
`define PMW_B_WAKE_PULSE 7
`define PMW_WCFG_MASK 16'h0380
`define PMW_B_INT_WAKE 6
`define PMW_SYNC_BYTE 8'hFF
`define PMW_SYNC_LAST 3'h6
`define PMW_MAC_LAST 3'h5
`define PMW_REP_LAST 4'hF
`endif

// ===== design/pmw_mgmt_regs.sv
// Management registers and wake-frame detector of a 10/100 PHY.
`timescale 1ns/100ps
`include "pmw_defines.svh"
module pmw_mgmt_regs #(
  parameter logic [4:0] PHY_ADDR = 5'h00,
  parameter logic [21:0] MAKER_ID = 22'h15A5A5, // Arbitrary value.
  parameter logic [5:0] MODEL_NO = 6'h05, // Arbitrary value.
  parameter logic [3:0] REV_NO = 4'h3 // Arbitrary value.
) (
  input wire logic i_ref_clk,
  input wire logic i_resetn,
  input wire logic i_mdc,
  input wire logic i_mdio,
  output logic o_mdio,
  output logic o_mdio_oe,
  input wire logic i_wake_strap,
  input wire pmw_pkg::pmw_rx_t i_rx,
  input wire logic i_tx_en,
  input wire logic i_link_up,
  input wire logic i_an_complete,
  input wire logic i_remote_fault,
  input wire logic i_an_full_duplex,
  input wire logic i_an_speed100,
  output logic o_first_indicator_pin,
  output logic o_general_interrupt_output_n,
  output logic o_col,
  output logic o_tx_en,
  output logic o_xmii_oe,
  output logic o_loopback,
  output logic o_power_down,
  output logic o_phy_reset,
  output logic o_an_restart,
  output logic o_full_duplex,
  output logic o_speed100,
  output logic [15:0] o_adv_active
);
  localparam int SRST_MAX = `PMW_SRST_CYC + 2;

  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (!i_resetn);

  pmw_pkg::pmw_mdio_st_t st_reg;
  pmw_pkg::pmw_acc_t acc_reg;
  logic [2:0] s0_reg, s1_reg, s2_reg, lvl_reg, lvl_next;
  logic mdc_rise, mdio_bit;
  logic [4:0] cnt_reg;
  logic [11:0] hdr_reg;
  logic [15:0] sh_reg, rd_word, ext_word, stat_word;
  logic rd_op_reg, mine_reg;
  logic [15:0] ctrl_reg, adv_reg, int_en_reg, ext_addr_reg;
  logic [15:0] wake_ctrl_reg, wake_cfg_reg, mac_hi_reg, mac_mid_reg, mac_lo_reg;
  logic [3:0] srst_cnt_reg;
  logic wr_ctrl, srst_start, srst_done, restart_evt;
  logic [2:0] boot_cnt_reg;
  logic strap_reg, boot_pulse;
  logic an_done_reg, rf_reg, link_ll_reg, link_d_reg, int_st_reg;
  logic wake_en, pulse_mode, wake_evt_reg, hunt_reg, wake_lvl_reg;
  logic [2:0] ff_cnt_reg, bidx_reg;
  logic [3:0] rcnt_reg;
  logic [47:0] mac_shift;
  logic [7:0] mac_byte;
  logic [6:0] pw_cnt_reg, pw_width;

  // ------------------------------------------------------------------
  // Pin synchronisers
  // ------------------------------------------------------------------
  // Three stages per pin; a new level counts once stages two and three agree.
  always_ff @(posedge i_ref_clk) begin
    if (!i_resetn) begin
      s0_reg <= 3'h0;
      s1_reg <= 3'h0;
      s2_reg <= 3'h0;
      lvl_reg <= 3'h0;
    end else begin
      s0_reg <= {i_wake_strap, i_mdio, i_mdc};
      s1_reg <= s0_reg;
      s2_reg <= s1_reg;
      lvl_reg <= lvl_next;
    end
  end

  // Filtered levels and the management clock rising edge.
  always_comb begin
    lvl_next = (s1_reg & s2_reg) | (lvl_reg & (s1_reg | s2_reg));
    mdc_rise = lvl_next[0] & ~lvl_reg[0];
    mdio_bit = lvl_next[1];
  end

  // Strap capture a few cycles after reset release, once the chain is full.
  always_ff @(posedge i_ref_clk) begin
    if (!i_resetn) begin
      boot_cnt_reg <= 3'h0;
      strap_reg <= 1'h0;
    end else if (boot_cnt_reg != 3'h4) begin
      boot_cnt_reg <= boot_cnt_reg + 3'h1;
      strap_reg <= s2_reg[2];
    end
  end
  assign boot_pulse = (boot_cnt_reg == 3'h3);

  // ------------------------------------------------------------------
  // Serial management frame engine
  // ------------------------------------------------------------------
  // Waits for the start bit, so frames need no preamble; reads drive MDIO
  // from the second turnaround bit and release it after the last data bit.
  always_ff @(posedge i_ref_clk) begin
    acc_reg.wr <= 1'h0;
    acc_reg.rd <= 1'h0;
    if (!i_resetn) begin
      st_reg <= pmw_pkg::MD_IDLE;
      cnt_reg <= 5'h00;
      hdr_reg <= 12'h000;
      sh_reg <= 16'h0000;
      rd_op_reg <= 1'h0;
      mine_reg <= 1'h0;
      acc_reg <= '0;
      o_mdio <= 1'h1;
      o_mdio_oe <= 1'h0;
    end else if (mdc_rise) begin
      case (st_reg)
        pmw_pkg::MD_IDLE: begin
          cnt_reg <= 5'h00;
          if (!mdio_bit) begin
            st_reg <= pmw_pkg::MD_HDR;
          end
        end
        pmw_pkg::MD_HDR: begin
          hdr_reg <= {hdr_reg[10:0], mdio_bit};
          cnt_reg <= cnt_reg + 5'h01;
          if (cnt_reg == 5'h0C) begin
            cnt_reg <= 5'h00;
            rd_op_reg <= hdr_reg[10];
            mine_reg <= (hdr_reg[8:4] == PHY_ADDR);
            acc_reg.addr <= {hdr_reg[3:0], mdio_bit};
            if (hdr_reg[11] && (hdr_reg[10] ^ hdr_reg[9])) begin
              st_reg <= pmw_pkg::MD_TA;
            end else begin
              st_reg <= pmw_pkg::MD_IDLE;
            end
          end
        end
        pmw_pkg::MD_TA: begin
          cnt_reg <= cnt_reg + 5'h01;
          if (cnt_reg == 5'h00) begin
            if (rd_op_reg && mine_reg) begin
              o_mdio_oe <= 1'h1;
              o_mdio <= 1'h0;
            end
          end else begin
            st_reg <= pmw_pkg::MD_DATA;
            cnt_reg <= 5'h00;
            if (rd_op_reg && mine_reg) begin
              o_mdio <= rd_word[15];
              sh_reg <= {rd_word[14:0], 1'h0};
              acc_reg.rd <= 1'h1;
            end
          end
        end
        pmw_pkg::MD_DATA: begin
          cnt_reg <= cnt_reg + 5'h01;
          if (rd_op_reg) begin
            o_mdio <= sh_reg[15];
            sh_reg <= {sh_reg[14:0], 1'h0};
          end else begin
            sh_reg <= {sh_reg[14:0], mdio_bit};
          end
          if (cnt_reg == 5'h0F) begin
            st_reg <= pmw_pkg::MD_IDLE;
            o_mdio_oe <= 1'h0;
            o_mdio <= 1'h1;
            if (!rd_op_reg && mine_reg) begin
              acc_reg.wr <= 1'h1;
              acc_reg.data <= {sh_reg[14:0], mdio_bit};
            end
          end
        end
        default: st_reg <= pmw_pkg::MD_IDLE;
      endcase
    end
  end

  // ------------------------------------------------------------------
  // Read data
  // ------------------------------------------------------------------
  // Register read multiplexer, extended window included.
  always_comb begin
    stat_word = `PMW_STAT_FIXED;
    stat_word[5] = an_done_reg;
    stat_word[4] = rf_reg;
    stat_word[2] = link_ll_reg;
    case (ext_addr_reg)
      `PMW_EXT_WAKE_CTRL: ext_word = wake_ctrl_reg;
      `PMW_EXT_WAKE_CFG: ext_word = wake_cfg_reg;
      `PMW_EXT_MAC_HI: ext_word = mac_hi_reg;
      `PMW_EXT_MAC_MID: ext_word = mac_mid_reg;
      `PMW_EXT_MAC_LO: ext_word = mac_lo_reg;
      default: ext_word = 16'h0000;
    endcase
    case (acc_reg.addr)
      `PMW_REG_CTRL: rd_word = {srst_cnt_reg != 4'h0, ctrl_reg[14:0]};
      `PMW_REG_STAT: rd_word = stat_word;
      `PMW_REG_ID_HI: rd_word = MAKER_ID[21:6];
      `PMW_REG_ID_LO: rd_word = {MAKER_ID[5:0], MODEL_NO, REV_NO};
      `PMW_REG_ADV: rd_word = adv_reg;
      `PMW_REG_INT_EN: rd_word = int_en_reg;
      `PMW_REG_INT_ST: rd_word = {9'h000, int_st_reg, 6'h00};
      `PMW_REG_EXT_ADDR: rd_word = ext_addr_reg;
      `PMW_REG_EXT_DATA: rd_word = ext_word;
      default: rd_word = 16'h0000;
    endcase
  end

  // ------------------------------------------------------------------
  // Basic control, soft reset and negotiation restart
  // ------------------------------------------------------------------
  assign wr_ctrl = acc_reg.wr && (acc_reg.addr == `PMW_REG_CTRL);
  assign srst_start = wr_ctrl && (acc_reg.data[15] ||
    (ctrl_reg[`PMW_B_PDN] && !acc_reg.data[`PMW_B_PDN]));
  assign srst_done = (srst_cnt_reg == 4'h1);
  assign restart_evt = boot_pulse || srst_done ||
    (wr_ctrl && acc_reg.data[`PMW_B_RESTART]);

  // Control word; restart bit never stored so it reads back cleared.
  always_ff @(posedge i_ref_clk) begin
    if (!i_resetn) begin
      ctrl_reg <= `PMW_CTRL_RST;
    end else if (wr_ctrl) begin
      ctrl_reg <= acc_reg.data & `PMW_CTRL_RW_MASK &
        (srst_start ? ~`PMW_CTRL_SWC_MASK : 16'hFFFF);
    end
  end

  // Soft reset timer; the reset bit reads 1 until it expires.
  always_ff @(posedge i_ref_clk) begin
    if (!i_resetn) begin
      srst_cnt_reg <= 4'h0;
    end else if (srst_start) begin
      srst_cnt_reg <= 4'(`PMW_SRST_CYC);
    end else if (srst_cnt_reg != 4'h0) begin
      srst_cnt_reg <= srst_cnt_reg - 4'h1;
    end
  end

  // Advertisement word and the copy that negotiation actually uses.
  always_ff @(posedge i_ref_clk) begin
    if (!i_resetn) begin
      adv_reg <= `PMW_ADV_RST;
      o_adv_active <= `PMW_ADV_RST;
      link_d_reg <= 1'h0;
    end else begin
      link_d_reg <= i_link_up;
      if (acc_reg.wr && (acc_reg.addr == `PMW_REG_ADV)) begin
        adv_reg <= (acc_reg.data & `PMW_ADV_RW_MASK) | `PMW_ADV_FIXED;
      end
      if (restart_evt || (link_d_reg && !i_link_up)) begin
        o_adv_active <= adv_reg;
      end
    end
  end

  // Mode outputs toward the data path.
  always_ff @(posedge i_ref_clk) begin
    if (!i_resetn) begin
      o_an_restart <= 1'h0;
      o_phy_reset <= 1'h0;
      o_loopback <= 1'h0;
      o_power_down <= 1'h0;
      o_full_duplex <= 1'h1;
      o_speed100 <= 1'h1;
      o_xmii_oe <= 1'h0;
      o_tx_en <= 1'h0;
      o_col <= 1'h0;
    end else begin
      o_an_restart <= restart_evt;
      o_phy_reset <= (srst_cnt_reg != 4'h0);
      o_loopback <= ctrl_reg[`PMW_B_LOOP];
      o_power_down <= ctrl_reg[`PMW_B_PDN];
      o_full_duplex <= ctrl_reg[`PMW_B_AN_EN] ? i_an_full_duplex :
        ctrl_reg[`PMW_B_DUP];
      o_speed100 <= ctrl_reg[`PMW_B_AN_EN] ? i_an_speed100 :
        ({ctrl_reg[`PMW_B_SPD_M], ctrl_reg[`PMW_B_SPD_L]} == 2'h1);
      o_xmii_oe <= !ctrl_reg[`PMW_B_ISO];
      o_tx_en <= i_tx_en && !ctrl_reg[`PMW_B_ISO];
      o_col <= ctrl_reg[`PMW_B_COLT] && i_tx_en && !ctrl_reg[`PMW_B_ISO];
    end
  end

  // ------------------------------------------------------------------
  // Status latches
  // ------------------------------------------------------------------
  // Fault and link latches: hardware wins over a read or soft reset in the same cycle; negotiation done reads 0 while the soft reset timer runs.
  always_ff @(posedge i_ref_clk) begin
    if (!i_resetn) begin
      an_done_reg <= 1'h0;
      rf_reg <= 1'h0;
      link_ll_reg <= 1'h0;
    end else begin
      an_done_reg <= i_an_complete && !(srst_cnt_reg != 4'h0);
      rf_reg <= i_remote_fault || (rf_reg && !srst_start &&
        !(acc_reg.rd && acc_reg.addr == `PMW_REG_STAT));
      if (!i_link_up || srst_start) begin
        link_ll_reg <= 1'h0;
      end else if (acc_reg.rd && acc_reg.addr == `PMW_REG_STAT) begin
        link_ll_reg <= 1'h1;
      end
    end
  end

  // ------------------------------------------------------------------
  // Extended wake registers
  // ------------------------------------------------------------------
  // Extended space is reached through an address word and a data word.
  always_ff @(posedge i_ref_clk) begin
    if (!i_resetn) begin
      ext_addr_reg <= 16'h0000;
      wake_ctrl_reg <= 16'h0000;
      wake_cfg_reg <= 16'h0000;
      mac_hi_reg <= 16'h0000;
      mac_mid_reg <= 16'h0000;
      mac_lo_reg <= 16'h0000;
    end else if (acc_reg.wr) begin
      if (acc_reg.addr == `PMW_REG_EXT_ADDR) begin
        ext_addr_reg <= acc_reg.data;
      end
      if (acc_reg.addr == `PMW_REG_EXT_DATA) begin
        case (ext_addr_reg)
          `PMW_EXT_WAKE_CTRL: wake_ctrl_reg <= acc_reg.data;
          `PMW_EXT_WAKE_CFG: wake_cfg_reg <= acc_reg.data & `PMW_WCFG_MASK;
          `PMW_EXT_MAC_HI: mac_hi_reg <= acc_reg.data;
          `PMW_EXT_MAC_MID: mac_mid_reg <= acc_reg.data;
          `PMW_EXT_MAC_LO: mac_lo_reg <= acc_reg.data;
          default: ext_addr_reg <= ext_addr_reg;
        endcase
      end
    end
  end

  // ------------------------------------------------------------------
  // Wake frame detector
  // ------------------------------------------------------------------
  assign wake_en = wake_ctrl_reg[`PMW_B_WAKE_EN];
  assign pulse_mode = wake_cfg_reg[`PMW_B_WAKE_PULSE];
  assign mac_shift = {mac_hi_reg, mac_mid_reg, mac_lo_reg} << {bidx_reg, 3'h0};
  assign mac_byte = mac_shift[47:40];

  // Six sync bytes, then sixteen copies of the address, anywhere in frame.
  always_ff @(posedge i_ref_clk) begin
    wake_evt_reg <= 1'h0;
    if (!i_resetn || !wake_en || !i_rx.frame) begin
      ff_cnt_reg <= 3'h0;
      hunt_reg <= 1'h0;
      bidx_reg <= 3'h0;
      rcnt_reg <= 4'h0;
    end else if (i_rx.valid) begin
      if (hunt_reg) begin
        if (i_rx.data == mac_byte) begin
          bidx_reg <= (bidx_reg == `PMW_MAC_LAST) ? 3'h0 : bidx_reg + 3'h1;
          if (bidx_reg == `PMW_MAC_LAST) begin
            rcnt_reg <= rcnt_reg + 4'h1;
            if (rcnt_reg == `PMW_REP_LAST) begin
              wake_evt_reg <= 1'h1;
              hunt_reg <= 1'h0;
              ff_cnt_reg <= 3'h0;
            end
          end
        end else begin
          hunt_reg <= 1'h0;
          bidx_reg <= 3'h0;
          rcnt_reg <= 4'h0;
          ff_cnt_reg <= (i_rx.data == `PMW_SYNC_BYTE) ? 3'h1 : 3'h0;
        end
      end else if (ff_cnt_reg == `PMW_SYNC_LAST && i_rx.data == mac_byte) begin
        hunt_reg <= 1'h1;
        bidx_reg <= 3'h1;
      end else if (i_rx.data == `PMW_SYNC_BYTE) begin
        if (ff_cnt_reg != `PMW_SYNC_LAST) begin
          ff_cnt_reg <= ff_cnt_reg + 3'h1;
        end
      end else begin
        ff_cnt_reg <= 3'h0;
      end
    end
  end

  // Pulse width selected by the two-bit field.
  always_comb begin
    case (wake_cfg_reg[9:8])
      2'h0: pw_width = 7'(`PMW_PW0_CYC);
      2'h1: pw_width = 7'(`PMW_PW1_CYC);
      2'h2: pw_width = 7'(`PMW_PW2_CYC);
      default: pw_width = 7'(`PMW_PW3_CYC);
    endcase
  end

  // Wake pin state: a held level until detection is disabled or pulse mode is set, or a pulse.
  always_ff @(posedge i_ref_clk) begin
    if (!i_resetn) begin
      pw_cnt_reg <= 7'h00;
      wake_lvl_reg <= 1'h0;
    end else begin
      if (wake_evt_reg && pulse_mode) begin
        pw_cnt_reg <= pw_width;
      end else if (pw_cnt_reg != 7'h00) begin
        pw_cnt_reg <= pw_cnt_reg - 7'h01;
      end
      if (wake_evt_reg && !pulse_mode) begin
        wake_lvl_reg <= 1'h1;
      end else if (!wake_en || pulse_mode) begin
        wake_lvl_reg <= 1'h0;
      end
    end
  end

  // Interrupt enable and the sticky wake status, cleared by reading it.
  always_ff @(posedge i_ref_clk) begin
    if (!i_resetn) begin
      int_en_reg <= 16'h0000;
      int_st_reg <= 1'h0;
    end else begin
      if (acc_reg.wr && acc_reg.addr == `PMW_REG_INT_EN) begin
        int_en_reg <= acc_reg.data;
      end
      int_st_reg <= wake_evt_reg || (int_st_reg &&
        !(acc_reg.rd && acc_reg.addr == `PMW_REG_INT_ST));
    end
  end

  // Pin drivers; a held level keeps the general line low, reads cannot clear it.
  always_ff @(posedge i_ref_clk) begin
    if (!i_resetn) begin
      o_first_indicator_pin <= 1'h1;
      o_general_interrupt_output_n <= 1'h1;
    end else begin
      o_first_indicator_pin <= strap_reg ?
        !(wake_lvl_reg || pw_cnt_reg != 7'h00) : !i_link_up;
      o_general_interrupt_output_n <= !(int_en_reg[`PMW_B_INT_WAKE] &&
        (int_st_reg || wake_lvl_reg));
    end
  end

  // ------------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------------
  sequence pulse_low_s;
    !o_first_indicator_pin [*8];
  endsequence
  sequence pulse_end_s;
    ##1 o_first_indicator_pin;
  endsequence

  chk_col_test: assert property (
    ctrl_reg[`PMW_B_COLT] && !ctrl_reg[`PMW_B_ISO] && i_tx_en |=> o_col)
    else $error("collision test not echoed");
  chk_isolate_out: assert property (
    ctrl_reg[`PMW_B_ISO] |=> !o_xmii_oe && !o_tx_en)
    else $error("isolate left outputs active");
  chk_restart_pulse: assert property (
    wr_ctrl && acc_reg.data[`PMW_B_RESTART] |=> o_an_restart)
    else $error("restart write gave no restart");
  chk_srst_ends: assert property (
    srst_start |=> ##1 o_phy_reset ##[1:SRST_MAX] (srst_cnt_reg == 4'h0))
    else $error("soft reset did not complete");
  chk_pdn_exit: assert property (
    wr_ctrl && ctrl_reg[`PMW_B_PDN] && !acc_reg.data[`PMW_B_PDN]
    |=> (srst_cnt_reg != 4'h0))
    else $error("power-down exit without reset");
  chk_wake_gate: assert property (
    !wake_en |=> !wake_evt_reg)
    else $error("wake event while disabled");
  chk_wake_general: assert property (
    wake_evt_reg && int_en_reg[`PMW_B_INT_WAKE] |-> ##2 !o_general_interrupt_output_n)
    else $error("wake not seen on general interrupt");
  chk_pulse_width: assert property (
    wake_evt_reg && strap_reg && pulse_mode && wake_cfg_reg[9:8] == 2'h0
    |-> ##2 pulse_low_s ##0 pulse_end_s)
    else $error("wake pulse width wrong");
  chk_fault_latch: assert property (
    i_remote_fault |=> rf_reg)
    else $error("remote fault not latched");
  chk_link_low: assert property (
    !i_link_up |=> !link_ll_reg)
    else $error("link status not latched low");
endmodule // pmw_mgmt_regs

// ===== design/pmw_pkg.sv
// Types shared by the PHY management register block.
package pmw_pkg;
  typedef enum logic [1:0] {MD_IDLE, MD_HDR, MD_TA, MD_DATA} pmw_mdio_st_t;
  typedef struct packed {
    logic frame;
    logic valid;
    logic [7:0] data;
  } pmw_rx_t;
  typedef struct packed {
    logic wr;
    logic rd;
    logic [4:0] addr;
    logic [15:0] data;
  } pmw_acc_t;
endpackage

// ===== verif/pmw_mdio_mgr.sv
// Station management controller model for the management link.
`timescale 1ns/100ps
module pmw_mdio_mgr (
  output logic o_mdc,
  output logic o_mdio,
  input wire logic i_mdio
);
  // Clock rests low and data is released high between frames.
  initial begin
    o_mdc = 1'b0;
    o_mdio = 1'b1;
  end
  // One 125 ns link clock; data moves while the clock is low.
  task automatic tick(input logic b, output logic s);
    o_mdio = b;
    #62.5 s = i_mdio;
    o_mdc = 1'b1;
    #62.5 o_mdc = 1'b0;
  endtask
  // Frame with two preamble ones, released for the read turnaround and data.
  task automatic frame(input logic rd, input logic [4:0] ra, input logic [15:0] wd,
                       output logic [15:0] q);
    logic [33:0] f;
    logic s;
    f = {4'hD, rd ? 2'b10 : 2'b01, 5'h00, ra, rd ? 18'h3FFFF : {2'b10, wd}};
    for (int i = 33; i >= 0; i--) begin
      tick(f[i], s);
      if (i < 16) begin
        q[i] = s;
      end
    end
    tick(1'b1, s);
  endtask
endmodule // pmw_mdio_mgr

// ===== verif/test_pmw_mgmt_regs.sv
// Self-checking bench of the management registers and wake detector.
`timescale 1ns/100ps
module test_pmw_mgmt_regs;
  logic clk, rstn, mdc, m_mdio, d_mdio, d_oe, tx_en, ind, gen, col;
  logic link, fault, txo, xoe, lpb, pdn, fdx, s100;
  logic [15:0] adv;
  pmw_pkg::pmw_rx_t rx;
  int failures = 0;
  int n_compared = 0;
  int cyc = 0;
  logic [15:0] q;
  logic [7:0] mac [6] = '{8'hA1, 8'hB2, 8'hC3, 8'hD4, 8'hE5, 8'hF6};
  // Shared data wire with its pull-up.
  wire mdio_w = m_mdio & (d_oe ? d_mdio : 1'b1);
  pmw_mdio_mgr mgr_u (.o_mdc(mdc), .o_mdio(m_mdio), .i_mdio(mdio_w));
  pmw_mgmt_regs #(.MAKER_ID(22'h2B1C3D)) dut_u (
    .i_ref_clk(clk), .i_resetn(rstn), .i_mdc(mdc), .i_mdio(mdio_w), .o_mdio(d_mdio),
    .o_mdio_oe(d_oe), .i_wake_strap(1'b1), .i_rx(rx), .i_tx_en(tx_en), .i_link_up(link),
    .i_an_complete(1'b0), .i_remote_fault(fault), .i_an_full_duplex(1'b1),
    .i_an_speed100(1'b1), .o_first_indicator_pin(ind), .o_general_interrupt_output_n(gen),
    .o_col(col), .o_tx_en(txo), .o_xmii_oe(xoe), .o_loopback(lpb), .o_power_down(pdn),
    .o_phy_reset(), .o_an_restart(), .o_full_duplex(fdx), .o_speed100(s100),
    .o_adv_active(adv));
  // Core clock.
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Hang guard.
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      failures++;
      final_report();
    end
  end
  task automatic check(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_compared++;
    if (g !== e) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    mgr_u.frame(1'b0, a, d, q);
  endtask
  task automatic wext(input logic [15:0] a, input logic [15:0] d);
    wr(5'h1E, a);
    wr(5'h1F, d);
  endtask
  task automatic rchk(input logic [4:0] a, input logic [15:0] e);
    mgr_u.frame(1'b1, a, 16'h0000, q);
    check($sformatf("reg %h", a), e, q);
  endtask
  task automatic byte_out(input logic [7:0] b);
    @(posedge clk) #1;
    rx = '{frame: 1'b1, valid: 1'b1, data: b};
  endtask
  // Wake frame placed after a stray byte, then a 200-cycle window counting low cycles.
  task automatic wake(input int w);
    int n;
    n = 0;
    byte_out(8'h55);
    repeat (6) byte_out(8'hFF);
    repeat (16) foreach (mac[i]) byte_out(mac[i]);
    @(posedge clk) #1;
    rx = '0;
    repeat (200) begin
      @(posedge clk) #1;
      n += (ind === 1'b0);
    end
    check("low cycles", w[15:0], n[15:0]);
  endtask
  task automatic t_regs();
    rchk(5'h00, 16'h1140);
    rchk(5'h01, 16'h7949);
    rchk(5'h02, 16'hAC70);
    rchk(5'h03, 16'hF453);
    rchk(5'h04, 16'h1DE1);
    rchk(5'h05, 16'h0000);
    $display("regs test done");
  endtask
  // Link status latches low until read; remote fault latches high until read.
  task automatic t_stat();
    @(posedge clk) #1 link = 1'b1;
    rchk(5'h01, 16'h7949);
    rchk(5'h01, 16'h794D);
    @(posedge clk) #1 link = 1'b0;
    @(posedge clk) #1 link = 1'b1;
    rchk(5'h01, 16'h7949);
    @(posedge clk) #1 fault = 1'b1;
    @(posedge clk) #1 fault = 1'b0;
    rchk(5'h01, 16'h795D);
    rchk(5'h01, 16'h794D);
    $display("status test done");
  endtask
  task automatic t_wake();
    wext(16'h4004, 16'hA1B2);
    wext(16'h4005, 16'hC3D4);
    wext(16'h4006, 16'hE5F6);
    wr(5'h12, 16'h0040);
    wake(0);
    wext(16'h4000, 16'h0004);
    for (int f = 0; f < 4; f++) begin
      wext(16'h4003, 16'h0080 | 16'(f << 8));
      wake(8 << f);
      check("gen low", 16'h0000, {15'h0, gen});
      rchk(5'h13, 16'h0040);
      repeat (3) @(posedge clk);
      check("gen clear", 16'h0001, {15'h0, gen});
    end
    wext(16'h4003, 16'h0000);
    // The pin falls one cycle into the window, so a held level fills the rest.
    wake(199);
    rchk(5'h13, 16'h0040);
    check("gen held", 16'h0000, {15'h0, gen});
    wext(16'h4000, 16'h0000);
    check("level off", 16'h0001, {15'h0, ind});
    check("gen off", 16'h0001, {15'h0, gen});
    $display("wake test done");
  endtask
  task automatic t_ctrl();
    wr(5'h00, 16'h11C0);
    @(posedge clk) #1 tx_en = 1'b1;
    repeat (3) @(posedge clk);
    check("col", 16'h0001, {15'h0, col});
    check("tx out", 16'h0001, {15'h0, txo});
    wr(5'h00, 16'h0500);
    check("iso oe", 16'h0000, {15'h0, xoe});
    check("iso tx", 16'h0000, {15'h0, txo});
    check("col off", 16'h0000, {15'h0, col});
    check("dup man", 16'h0001, {15'h0, fdx});
    check("spd 10", 16'h0000, {15'h0, s100});
    @(posedge clk) #1 tx_en = 1'b0;
    wr(5'h00, 16'h6000);
    check("loop", 16'h0001, {15'h0, lpb});
    check("half", 16'h0000, {15'h0, fdx});
    check("spd 100", 16'h0001, {15'h0, s100});
    wr(5'h04, 16'h0000);
    rchk(5'h04, 16'h0001);
    check("adv held", 16'h1DE1, adv);
    wr(5'h00, 16'h1200);
    rchk(5'h00, 16'h1000);
    check("adv new", 16'h0001, adv);
    wr(5'h00, 16'h1800);
    check("pdn on", 16'h0001, {15'h0, pdn});
    wr(5'h00, 16'h1000);
    check("pdn off", 16'h0000, {15'h0, pdn});
    wr(5'h00, 16'h91C0);
    rchk(5'h00, 16'h1140);
    $display("ctrl test done");
  endtask
  task automatic final_report();
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // Reset for 16 cycles, then the scenarios in turn.
  initial begin
    rstn = 1'b0;
    tx_en = 1'b0;
    link = 1'b0;
    fault = 1'b0;
    rx = '0;
    repeat (16) @(posedge clk);
    #1 rstn = 1'b1;
    repeat (10) @(posedge clk);
    t_regs();
    t_stat();
    t_wake();
    t_ctrl();
    final_report();
  end
endmodule // test_pmw_mgmt_regs
